//--- include/regulator_pkg.sv
package regulator_pkg;

    // ****************************************************************
    // Protection key and mode codes.
    // ****************************************************************
    localparam logic [15:0] KEY_UNLOCK = 16'h0096;
    localparam logic [15:0] KEY_RESET = 16'h0000;
    localparam logic [2:0] MODE_AUTO = 3'h0;
    localparam logic [2:0] MODE_NORMAL = 3'h2;
    localparam logic [2:0] MODE_ECONOMY = 3'h3;
    localparam logic [2:0] MODE_SUPER = 3'h5;
    localparam logic [2:0] MODE_RESET = 3'h0;
    localparam logic [1:0] DIV_RESET = 2'h0;

    // ****************************************************************
    // Link write targets.
    // ****************************************************************
    localparam logic [1:0] SEL_PROTECT = 2'h0;
    localparam logic [1:0] SEL_CONTROL = 2'h1;
    localparam logic [1:0] SEL_TIMING = 2'h2;

    // ****************************************************************
    // Timing in microseconds and cycles at a 50 MHz clock.
    // ****************************************************************
    localparam int CLK_MHZ = 50;
    localparam int STOP_WAIT_US = 1000;
    localparam int EXIT_WAIT_US = 10000;
    localparam int STOP_WAIT_CYCLES = STOP_WAIT_US * CLK_MHZ;
    localparam int EXIT_WAIT_CYCLES = EXIT_WAIT_US * CLK_MHZ;
    localparam int COUNT_W = 20;

    // ****************************************************************
    // Controller register offsets, bit positions and answers.
    // ****************************************************************
    localparam logic [5:0] OFS_KEY = 6'h00;
    localparam logic [5:0] OFS_MODE = 6'h04;
    localparam logic [5:0] OFS_DIV = 6'h08;
    localparam logic [5:0] OFS_STATUS = 6'h0C;
    localparam logic [5:0] OFS_IRQ_STATUS = 6'h10;
    localparam logic [5:0] OFS_IRQ_MASK = 6'h14;
    localparam int BIT_DONE = 0;
    localparam int BIT_REFUSED = 1;
    localparam logic [1:0] IRQ_RESET = 2'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Pending automatic transition.
    typedef enum logic [1:0] {WAIT_NONE, WAIT_STOP, WAIT_SLEEP} wait_e;

    // Codes in which the regulator runs its reduced drive setting.
    function automatic logic mode_is_light(input logic [2:0] code);
        mode_is_light = (code == MODE_ECONOMY) || (code == MODE_SUPER);
    endfunction : mode_is_light

endpackage : regulator_pkg

//--- include/regulator_link.sv
`timescale 1ns/1ps
`default_nettype none
// Register write path from controller to regulator, plus status back.
interface regulator_link;
    logic wr_valid;
    logic [1:0] wr_sel;
    logic [15:0] wr_data;
    logic [2:0] regulator_mode_sel;
    logic [1:0] pump_clock_divider;
    logic unlocked;
    logic economy;
    logic mode_done_flag;

    modport device (
        input wr_valid, wr_sel, wr_data,
        output regulator_mode_sel, pump_clock_divider, unlocked, economy, mode_done_flag
    );
    modport controller (
        output wr_valid, wr_sel, wr_data,
        input regulator_mode_sel, pump_clock_divider, unlocked, economy, mode_done_flag
    );
endinterface : regulator_link
`default_nettype wire

//--- verilog/regulator_mode_unit.sv
// Chosen here: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module regulator_mode_unit
    import regulator_pkg::*;
#(
    parameter int STOP_WAIT = STOP_WAIT_CYCLES,
    parameter int EXIT_WAIT = EXIT_WAIT_CYCLES
)
(
    input wire logic aclk,
    input wire logic aresetn,
    regulator_link.device link,
    input wire logic fast_clock_running,
    input wire logic sleep_entry,
    input wire logic sleep_keep_lowspeed,
    input wire logic cpu_wake,
    input wire logic lowspeed_crystal_clock,
    output logic economy_active,
    output logic pump_enable,
    output logic pump_clock
);

    // ****************************************************************
    // Wait lengths cut to the counter width.
    // ****************************************************************
    localparam logic [COUNT_W-1:0] STOP_LAST = COUNT_W'(STOP_WAIT - 1);
    localparam logic [COUNT_W-1:0] EXIT_LAST = COUNT_W'(EXIT_WAIT - 1);
    localparam logic [COUNT_W-1:0] COUNT_ZERO = '0;

    typedef struct packed {
        logic [15:0] protect_key;
        logic [2:0] mode;
        logic [1:0] divider;
        logic economy;
        logic in_sleep;
        wait_e waiting;
        logic [COUNT_W-1:0] count;
        logic exit_busy;
        logic [COUNT_W-1:0] exit_count;
        logic done;
        logic lowspeed_q;
        logic [3:0] pump_count;
        logic pump_clk;
        logic pump_on;
    } dev_s;

    dev_s state;
    dev_s next_state;
    logic [3:0] pump_last;
    logic auto_mode;

    // Pump half period in lowspeed edges: 1, 2, 4 or 8.
    assign pump_last = 4'((4'h1 << state.divider) - 4'h1);
    assign auto_mode = (state.mode == MODE_AUTO);

    // ****************************************************************
    // Next state.
    // ****************************************************************
    // Priority: writes, wake, sleep entry, clock tracking, timers.
    always_comb
    begin
        next_state = state;
        next_state.done = 1'b0;
        next_state.lowspeed_q = lowspeed_crystal_clock;

        // Software writes over the link; the key register is always open.
        if (link.wr_valid)
        begin
            if (link.wr_sel == SEL_PROTECT)
            begin
                next_state.protect_key = link.wr_data;
            end
            else if (state.protect_key == KEY_UNLOCK)
            begin
                if (link.wr_sel == SEL_TIMING)
                begin
                    next_state.divider = link.wr_data[1:0];
                end
                else if (link.wr_sel == SEL_CONTROL)
                begin
                    next_state.mode = link.wr_data[2:0];
                    next_state.waiting = WAIT_NONE;
                    next_state.count = COUNT_ZERO;
                    case (link.wr_data[2:0])
                        MODE_NORMAL:
                        begin
                            next_state.economy = 1'b0;
                        end
                        MODE_ECONOMY:
                        begin
                            next_state.economy = 1'b1;
                        end
                        MODE_SUPER:
                        begin
                            next_state.economy = 1'b1;
                        end
                        MODE_AUTO:
                        begin
                            // Automatic starts at the drive the clocks need.
                            next_state.economy = ~fast_clock_running;
                        end
                        default:
                        begin
                            next_state.economy = state.economy;
                        end
                    endcase
                    // Leaving the pump for automatic or economy starts the settling timer.
                    if ((state.mode == MODE_SUPER) &&
                        ((link.wr_data[2:0] == MODE_AUTO) ||
                         (link.wr_data[2:0] == MODE_ECONOMY)))
                    begin
                        next_state.exit_busy = 1'b1;
                        next_state.exit_count = COUNT_ZERO;
                    end
                end
            end
        end
        // Automatic transitions, held off while any link write lands.
        else if (auto_mode)
        begin
            if (cpu_wake && state.in_sleep)
            begin
                next_state.in_sleep = 1'b0;
                next_state.waiting = WAIT_NONE;
                next_state.economy = ~fast_clock_running;
            end
            else if (sleep_entry && !state.in_sleep)
            begin
                next_state.in_sleep = 1'b1;
                if (!state.economy && !fast_clock_running)
                begin
                    if (sleep_keep_lowspeed)
                    begin
                        next_state.waiting = WAIT_SLEEP;
                        next_state.count = COUNT_ZERO;
                    end
                    else
                    begin
                        next_state.economy = 1'b1;
                        next_state.waiting = WAIT_NONE;
                    end
                end
            end
            else if (fast_clock_running)
            begin
                // A fast source gets full drive at the first clock edge that sees it.
                next_state.economy = 1'b0;
                next_state.waiting = WAIT_NONE;
            end
            else if (!state.economy)
            begin
                case (state.waiting)
                    WAIT_NONE:
                    begin
                        next_state.waiting = WAIT_STOP;
                        next_state.count = COUNT_ZERO;
                    end
                    WAIT_STOP, WAIT_SLEEP:
                    begin
                        if (state.count == STOP_LAST)
                        begin
                            next_state.economy = 1'b1;
                            next_state.done = 1'b1;
                            next_state.waiting = WAIT_NONE;
                        end
                        else
                        begin
                            next_state.count = COUNT_W'(state.count + 1'b1);
                        end
                    end
                    default:
                    begin
                        next_state.waiting = WAIT_NONE;
                    end
                endcase
            end
        end
        else
        begin
            // Fixed modes only track sleep so a later automatic wake is right.
            if (cpu_wake)
            begin
                next_state.in_sleep = 1'b0;
            end
            else if (sleep_entry)
            begin
                next_state.in_sleep = 1'b1;
            end
        end

        // Settling timer after leaving the pump, in any mode.
        if (state.exit_busy && !(link.wr_valid && next_state.exit_busy &&
            state.mode == MODE_SUPER))
        begin
            if (state.exit_count == EXIT_LAST)
            begin
                next_state.exit_busy = 1'b0;
                next_state.done = 1'b1;
            end
            else
            begin
                next_state.exit_count = COUNT_W'(state.exit_count + 1'b1);
            end
        end

        // Pump clock comes only from lowspeed edges.
        next_state.pump_on = (next_state.mode == MODE_SUPER);
        if (!state.pump_on)
        begin
            next_state.pump_count = 4'h0;
            next_state.pump_clk = 1'b0;
        end
        else if (lowspeed_crystal_clock && !state.lowspeed_q)
        begin
            if (state.pump_count >= pump_last)
            begin
                next_state.pump_count = 4'h0;
                next_state.pump_clk = ~state.pump_clk;
            end
            else
            begin
                next_state.pump_count = 4'(state.pump_count + 4'h1);
            end
        end
    end

    // ****************************************************************
    // State register.
    // ****************************************************************
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state.protect_key <= KEY_RESET;
            state.mode <= MODE_RESET;
            state.divider <= DIV_RESET;
            state.economy <= 1'b0;
            state.in_sleep <= 1'b0;
            state.waiting <= WAIT_NONE;
            state.count <= COUNT_ZERO;
            state.exit_busy <= 1'b0;
            state.exit_count <= COUNT_ZERO;
            state.done <= 1'b0;
            state.lowspeed_q <= 1'b0;
            state.pump_count <= 4'h0;
            state.pump_clk <= 1'b0;
            state.pump_on <= 1'b0;
        end
        else
        begin
            state <= next_state;
        end
    end

    // ****************************************************************
    // Outputs, all from flip-flops except unlocked, a compare on protect_key.
    // ****************************************************************
    // The economy request is a level the analog side follows directly.
    assign economy_active = state.economy;
    assign pump_enable = state.pump_on;
    assign pump_clock = state.pump_clk;
    assign link.regulator_mode_sel = state.mode;
    assign link.pump_clock_divider = state.divider;
    assign link.unlocked = (state.protect_key == KEY_UNLOCK);
    assign link.economy = state.economy;
    assign link.mode_done_flag = state.done;

endmodule : regulator_mode_unit
`default_nettype wire

//--- verilog/regulator_controller.sv
`timescale 1ns/1ps
`default_nettype none
module regulator_controller
    import regulator_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    regulator_link.controller link,
    input wire logic [5:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [5:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic irq
);

    typedef struct packed {
        logic aw_have;
        logic [5:0] awaddr;
        logic w_have;
        logic [15:0] wdata;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic wr_valid;
        logic [1:0] wr_sel;
        logic [15:0] wr_data;
        logic settled;
        logic [1:0] irq_status;
        logic [1:0] irq_mask;
    } ctl_s;

    ctl_s state;
    ctl_s next_state;
    logic [1:0] events;
    logic [1:0] clear_bits;

    // One write and one read at a time: channels close while answering.
    assign s_axi_awready = !state.aw_have && !state.bvalid;
    assign s_axi_wready = !state.w_have && !state.bvalid;
    assign s_axi_arready = !state.rvalid;

    // ****************************************************************
    // Next state.
    // ****************************************************************
    always_comb
    begin
        next_state = state;
        next_state.wr_valid = 1'b0;
        events = 2'h0;
        clear_bits = 2'h0;
        events[BIT_DONE] = link.mode_done_flag;
        if (link.mode_done_flag)
        begin
            next_state.settled = 1'b1;
        end

        if (s_axi_awvalid && s_axi_awready)
        begin
            next_state.aw_have = 1'b1;
            next_state.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            next_state.w_have = 1'b1;
            next_state.wdata = s_axi_wdata[15:0];
        end

        // Write once address and data are both held.
        if (state.aw_have && state.w_have)
        begin
            next_state.aw_have = 1'b0;
            next_state.w_have = 1'b0;
            next_state.bvalid = 1'b1;
            next_state.bresp = RESP_OKAY;
            next_state.wr_data = state.wdata;
            case (state.awaddr)
                OFS_KEY:
                begin
                    next_state.wr_valid = 1'b1;
                    next_state.wr_sel = SEL_PROTECT;
                end
                OFS_MODE:
                begin
                    // Pump straight to normal would starve the core; refuse it.
                    if ((link.regulator_mode_sel == MODE_SUPER) &&
                        (state.wdata[2:0] == MODE_NORMAL))
                    begin
                        events[BIT_REFUSED] = 1'b1;
                    end
                    else
                    begin
                        next_state.wr_valid = 1'b1;
                        next_state.wr_sel = SEL_CONTROL;
                        if (link.unlocked && (link.regulator_mode_sel == MODE_SUPER))
                        begin
                            next_state.settled = 1'b0;
                        end
                    end
                end
                OFS_DIV:
                begin
                    next_state.wr_valid = 1'b1;
                    next_state.wr_sel = SEL_TIMING;
                end
                OFS_STATUS:
                begin
                    next_state.bresp = RESP_OKAY;
                end
                OFS_IRQ_STATUS:
                begin
                    clear_bits = state.wdata[1:0];
                end
                OFS_IRQ_MASK:
                begin
                    next_state.irq_mask = state.wdata[1:0];
                end
                default:
                begin
                    next_state.bresp = RESP_SLVERR;
                end
            endcase
        end
        if (state.bvalid && s_axi_bready)
        begin
            next_state.bvalid = 1'b0;
        end

        // A new event wins over a clear in the same cycle.
        next_state.irq_status = (state.irq_status & ~clear_bits) | events;

        // Reads answer one cycle after the address is taken.
        if (s_axi_arvalid && s_axi_arready)
        begin
            next_state.rvalid = 1'b1;
            next_state.rresp = RESP_OKAY;
            next_state.rdata = 32'h0000_0000;
            case (s_axi_araddr)
                OFS_KEY:
                begin
                    next_state.rdata[0] = link.unlocked;
                end
                OFS_MODE:
                begin
                    next_state.rdata[2:0] = link.regulator_mode_sel;
                end
                OFS_DIV:
                begin
                    next_state.rdata[1:0] = link.pump_clock_divider;
                end
                OFS_STATUS:
                begin
                    next_state.rdata[2:0] = {link.economy, link.unlocked, state.settled};
                end
                OFS_IRQ_STATUS:
                begin
                    next_state.rdata[1:0] = state.irq_status;
                end
                OFS_IRQ_MASK:
                begin
                    next_state.rdata[1:0] = state.irq_mask;
                end
                default:
                begin
                    next_state.rresp = RESP_SLVERR;
                end
            endcase
        end
        else if (state.rvalid && s_axi_rready)
        begin
            next_state.rvalid = 1'b0;
        end
    end

    // ****************************************************************
    // State register.
    // ****************************************************************
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state <= '0;
            state.settled <= 1'b1;
            state.irq_status <= IRQ_RESET;
            state.irq_mask <= IRQ_RESET;
        end
        else
        begin
            state <= next_state;
        end
    end

    // ****************************************************************
    // Outputs.
    // ****************************************************************
    assign s_axi_bvalid = state.bvalid;
    assign s_axi_bresp = state.bresp;
    assign s_axi_rvalid = state.rvalid;
    assign s_axi_rdata = state.rdata;
    assign s_axi_rresp = state.rresp;
    assign link.wr_valid = state.wr_valid;
    assign link.wr_sel = state.wr_sel;
    assign link.wr_data = state.wr_data;
    assign irq = |(state.irq_status & state.irq_mask);

endmodule : regulator_controller
`default_nettype wire

//--- tb/regulator_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ****************
// Link checker.
// ****************
module regulator_chk
    import regulator_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic wr_valid,
    input wire logic [1:0] wr_sel,
    input wire logic [15:0] wr_data,
    input wire logic [2:0] regulator_mode_sel,
    input wire logic [1:0] pump_clock_divider,
    input wire logic unlocked,
    input wire logic economy,
    input wire logic mode_done_flag
);
    default clocking dc @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // Decoded link writes.
    wire logic wk = wr_valid && wr_sel == SEL_PROTECT;
    wire logic wm = wr_valid && wr_sel == SEL_CONTROL;
    wire logic wd = wr_valid && wr_sel == SEL_TIMING;
    wire logic [2:0] md = wr_data[2:0];
    wire logic lt = mode_is_light(regulator_mode_sel);
    property p_unlock; wk && wr_data == KEY_UNLOCK |=> unlocked; endproperty
    a_unlock: assert property (p_unlock) else $error("key not open");
    property p_lock; wk && wr_data != KEY_UNLOCK |=> !unlocked; endproperty
    a_lock: assert property (p_lock) else $error("key not shut");
    property p_mode_hold; wm && !unlocked |=> $stable(regulator_mode_sel); endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("locked mode moved");
    property p_div_hold; wd && !unlocked |=> $stable(pump_clock_divider); endproperty
    a_div_hold: assert property (p_div_hold) else $error("locked divider moved");
    property p_mode_set; wm && unlocked |=> regulator_mode_sel == $past(md); endproperty
    a_mode_set: assert property (p_mode_set) else $error("mode not taken");
    property p_normal; regulator_mode_sel == MODE_NORMAL [*2] |-> !economy; endproperty
    a_normal: assert property (p_normal) else $error("economy in normal");
    property p_light; lt [*2] |-> economy; endproperty
    a_light: assert property (p_light) else $error("full drive in light mode");
    property p_done; mode_done_flag && regulator_mode_sel == MODE_AUTO |-> economy; endproperty
    a_done: assert property (p_done) else $error("done without economy");
    property p_pulse; mode_done_flag |=> !mode_done_flag; endproperty
    a_pulse: assert property (p_pulse) else $error("done too long");
endmodule : regulator_chk
`default_nettype wire

//--- tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
// ****************
// Controller and regulator pair.
// ****************
module testbench
    import regulator_pkg::*;
;
    localparam int SW = 20;
    localparam int EW = 50;
    logic aclk = 1'b0, aresetn = 1'b0, fast = 1'b1, slp = 1'b0, keep = 1'b0, wake = 1'b0;
    logic lsc = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b1;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b1, econ, pump_en, irq;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [5:0] s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
    logic [31:0] s_axi_wdata = 32'h00000000, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    int n_errors = 0, check_count = 0, n;
    regulator_link link ();
    regulator_mode_unit #(.STOP_WAIT(SW), .EXIT_WAIT(EW)) regulator_mode_unit_i (.aclk(aclk),
        .aresetn(aresetn), .link(link.device), .fast_clock_running(fast), .sleep_entry(slp),
        .sleep_keep_lowspeed(keep), .cpu_wake(wake), .lowspeed_crystal_clock(lsc),
        .economy_active(econ), .pump_enable(pump_en), .pump_clock());
    regulator_controller regulator_controller_i (.link(link.controller), .*);
    regulator_chk regulator_chk_i (.aclk(aclk), .aresetn(aresetn), .wr_valid(link.wr_valid),
        .wr_sel(link.wr_sel), .wr_data(link.wr_data), .unlocked(link.unlocked),
        .regulator_mode_sel(link.regulator_mode_sel), .economy(link.economy),
        .pump_clock_divider(link.pump_clock_divider), .mode_done_flag(link.mode_done_flag));
    // Free clocks; the slow one stands in for the crystal.
    initial forever #10 aclk = ~aclk;
    always @(posedge aclk) lsc <= ~lsc;
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : results
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e)
        begin
            n_errors++;
            $display("unexpected at %0t: saw %h wanted %h", $time, s, e);
        end
    endtask : chk
    // Ready and answers are taken at the rising edge; bready and rready stay high.
    task automatic wr(input logic [5:0] a, input logic [31:0] v, input logic [1:0] er);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        for (int i = 0; i < 50; i++)
        begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1)
            begin
                chk(s_axi_bresp, er);
                return;
            end
        end
        chk(0, 1);
        results();
    endtask : wr
    task automatic rd(input logic [5:0] a, input logic [31:0] ev, input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        for (int i = 0; i < 50; i++)
        begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1)
            begin
                chk(s_axi_rresp, er);
                if (er == RESP_OKAY) chk(s_axi_rdata, ev);
                return;
            end
        end
        chk(0, 1);
        results();
    endtask : rd
    task automatic step(input logic f, input logic s, input logic k, input logic w);
        fast <= f;
        slp <= s;
        keep <= k;
        wake <= w;
        @(posedge aclk);
        slp <= 1'b0;
        wake <= 1'b0;
    endtask : step
    task automatic look(input logic e);
        @(posedge aclk);
        chk(econ, e);
    endtask : look
    // The done pulse lasts one cycle.
    task automatic wait_done();
        for (n = 1; n < 1000; n++)
        begin
            @(posedge aclk);
            if (link.mode_done_flag === 1'b1) break;
        end
    endtask : wait_done
    // Main sequence.
    initial
    begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        wr(OFS_MODE, MODE_NORMAL, RESP_OKAY);
        wr(OFS_DIV, 32'h3, RESP_OKAY);
        rd(OFS_MODE, MODE_RESET, RESP_OKAY);
        rd(OFS_DIV, DIV_RESET, RESP_OKAY);
        wr(OFS_KEY, KEY_UNLOCK, RESP_OKAY);
        rd(OFS_KEY, 32'h1, RESP_OKAY);
        wr(OFS_MODE, MODE_NORMAL, RESP_OKAY);
        rd(OFS_MODE, MODE_NORMAL, RESP_OKAY);
        look(1'b0);
        step(1'b0, 1'b0, 1'b0, 1'b0);
        wr(OFS_MODE, MODE_ECONOMY, RESP_OKAY);
        look(1'b1);
        step(1'b1, 1'b0, 1'b0, 1'b0);
        wr(OFS_MODE, MODE_AUTO, RESP_OKAY);
        look(1'b0);
        $display("test locking done");
        step(1'b0, 1'b0, 1'b0, 1'b0);
        wait_done();
        chk(n >= SW - 2 && n <= SW + 2, 1);
        look(1'b1);
        step(1'b1, 1'b0, 1'b0, 1'b0);
        look(1'b0);
        step(1'b1, 1'b1, 1'b0, 1'b0);
        look(1'b0);
        step(1'b1, 1'b0, 1'b0, 1'b1);
        step(1'b0, 1'b1, 1'b0, 1'b0);
        look(1'b1);
        wait_done();
        chk(n, 1000);
        step(1'b1, 1'b0, 1'b0, 1'b1);
        look(1'b0);
        step(1'b0, 1'b1, 1'b1, 1'b0);
        look(1'b0);
        wait_done();
        chk(n >= SW - 3 && n <= SW + 2, 1);
        look(1'b1);
        $display("test automatic done");
        wr(OFS_DIV, 32'h1, RESP_OKAY);
        rd(OFS_DIV, 32'h1, RESP_OKAY);
        wr(OFS_MODE, MODE_SUPER, RESP_OKAY);
        rd(OFS_MODE, MODE_SUPER, RESP_OKAY);
        chk(pump_en, 1'b1);
        step(1'b0, 1'b1, 1'b1, 1'b0);
        wr(OFS_MODE, MODE_NORMAL, RESP_OKAY);
        rd(OFS_MODE, MODE_SUPER, RESP_OKAY);
        wr(OFS_IRQ_MASK, 32'h2, RESP_OKAY);
        rd(OFS_IRQ_STATUS, 32'h3, RESP_OKAY);
        chk(irq, 1'b1);
        wr(OFS_IRQ_STATUS, 32'h3, RESP_OKAY);
        rd(OFS_IRQ_STATUS, 32'h0, RESP_OKAY);
        chk(irq, 1'b0);
        wr(OFS_MODE, MODE_AUTO, RESP_OKAY);
        wait_done();
        chk(n >= EW - 4 && n <= EW + 2, 1);
        rd(OFS_STATUS, 32'h7, RESP_OKAY);
        rd(OFS_IRQ_STATUS, 32'h1, RESP_OKAY);
        chk(irq, 1'b0);
        $display("test super economy done");
        wr(OFS_KEY, KEY_RESET, RESP_OKAY);
        rd(OFS_KEY, 32'h0, RESP_OKAY);
        wr(OFS_MODE, MODE_NORMAL, RESP_OKAY);
        rd(OFS_MODE, MODE_AUTO, RESP_OKAY);
        wr(6'h3C, 32'h0, RESP_SLVERR);
        rd(6'h3C, 32'h0, RESP_SLVERR);
        $display("test map done");
        results();
    end
endmodule : testbench
`default_nettype wire
